// *** hdl/exec_pkg.sv ***
/*
  Shared constants for the move / swap / table-read execution block:
  opcode patterns, field positions, state and phase codes, default
  addresses of the special file locations and reset values.
  Assumes a 16-bit instruction word and an 8-bit data file.
*/
package exec_pkg;

  localparam int DATA_W  = 8;
  localparam int ADDR_W  = 8;
  localparam int PROG_W  = 16;
  localparam int INSTR_W = 16;

  // instruction field positions
  localparam int OPC_MSB  = 15;
  localparam int PF_LSB   = 13;
  localparam int WF_LSB   = 8;
  localparam int SWAP_LSB = 9;
  localparam int TBL_LSB  = 10;
  localparam int SRC_MSB  = 12;
  localparam int SRC_LSB  = 8;
  localparam int FILE_MSB = 7;
  localparam int FILE_LSB = 0;
  localparam int DEST_BIT = 8;
  localparam int INC_BIT  = 8;
  localparam int SEL_BIT  = 9;
  localparam int SRC_PAD  = ADDR_W - (SRC_MSB - SRC_LSB + 1);

  // opcode patterns in the top bits
  localparam logic [2:0] PF_CODE   = 3'h2;
  localparam logic [7:0] WF_CODE   = 8'h01;
  localparam logic [6:0] SWAP_CODE = 7'h0E;
  localparam logic [5:0] TBL_CODE  = 6'h2A;

  // nibble bounds
  localparam int NIB_HI_MSB = 7;
  localparam int NIB_HI_LSB = 4;
  localparam int NIB_LO_MSB = 3;
  localparam int NIB_LO_LSB = 0;

  // default special file locations (arbitrary plain values)
  localparam logic [ADDR_W-1:0] WREG_ADDR_DEF = 8'h0A;
  localparam logic [ADDR_W-1:0] IND0_ADDR_DEF = 8'h00;
  localparam logic [ADDR_W-1:0] IND1_ADDR_DEF = 8'h08;
  localparam logic [ADDR_W-1:0] PCL_ADDR_DEF  = 8'h02;

  // reset values
  localparam logic [PROG_W-1:0] PTR_RST   = 16'h0000;
  localparam logic [PROG_W-1:0] LATCH_RST = 16'h0000;
  localparam logic [ADDR_W-1:0] ADDR_RST  = 8'h00;
  localparam logic [DATA_W-1:0] DATA_RST  = 8'h00;
  localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;

  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_C1   = 2'b01,
    S_C2   = 2'b10,
    S_C3   = 2'b11
  } state_e;

  typedef enum logic [1:0] {
    PH_Q1 = 2'b00,
    PH_Q2 = 2'b01,
    PH_Q3 = 2'b10,
    PH_Q4 = 2'b11
  } phase_e;

  typedef enum logic [2:0] {
    OP_NONE    = 3'b000,
    OP_PF_MOVE = 3'b001,
    OP_WF_MOVE = 3'b010,
    OP_SWAP    = 3'b011,
    OP_TBL_RD  = 3'b100
  } op_e;

endpackage

// *** hdl/swap_if.sv ***
/*
  Carrier between the executor and its nibble swap unit.
  Assumes both ends sit in the same clock domain; the path is combinational.
*/
`timescale 1ns/1ns
interface swap_if;
  logic [7:0] raw;
  logic [7:0] swapped;
  modport unit (input raw, output swapped);
  modport user (output raw, input swapped);
endinterface

// *** hdl/nibble_swap_unit.sv ***
/*
  Nibble swap datapath for the swap instruction.
  Assumes the caller registers the result; no state is held here.
*/
`timescale 1ns/1ns
module nibble_swap_unit
  import exec_pkg::*;
(
  swap_if.unit sw
);

  assign sw.swapped = {sw.raw[NIB_LO_MSB:NIB_LO_LSB], sw.raw[NIB_HI_MSB:NIB_HI_LSB]};

endmodule

// *** hdl/move_swap_table_read_exec.sv ***
/*
  Execution logic for the peripheral-to-file move, working-register move,
  nibble swap and program table read, one MCLK_IN edge per Q phase.
  Assumes the data file answers RD_ADDR_OUT within the same phase and
  program memory drives PROG_DATA_IN while PROG_OE_N_OUT is low.
*/
`timescale 1ns/1ns
module move_swap_table_read_exec
  import exec_pkg::*;
#(
  parameter logic [ADDR_W-1:0] WREG_ADDR = WREG_ADDR_DEF,
  parameter logic [ADDR_W-1:0] IND0_ADDR = IND0_ADDR_DEF,
  parameter logic [ADDR_W-1:0] IND1_ADDR = IND1_ADDR_DEF,
  parameter logic [ADDR_W-1:0] PCL_ADDR  = PCL_ADDR_DEF
) (
  input  wire logic               MCLK_IN,
  input  wire logic               RST_IN,
  input  wire logic               INSTR_VALID_IN,
  input  wire logic [INSTR_W-1:0] INSTR_IN,
  input  wire logic [ADDR_W-1:0]  FSR0_IN,
  input  wire logic [ADDR_W-1:0]  FSR1_IN,
  input  wire logic [DATA_W-1:0]  RD_DATA_IN,
  input  wire logic [PROG_W-1:0]  PROG_DATA_IN,
  input  wire logic               PTR_LOAD_IN,
  input  wire logic [PROG_W-1:0]  PTR_DATA_IN,
  output logic                    BUSY_OUT,
  output logic [ADDR_W-1:0]       RD_ADDR_OUT,
  output logic [ADDR_W-1:0]       WR_ADDR_OUT,
  output logic [DATA_W-1:0]       WR_DATA_OUT,
  output logic                    WR_EN_OUT,
  output logic                    ZERO_WE_OUT,
  output logic                    ZERO_OUT,
  output logic [PROG_W-1:0]       PROG_ADDR_OUT,
  output logic                    PROG_OE_N_OUT,
  output logic [PROG_W-1:0]       PTR_OUT,
  output logic [PROG_W-1:0]       LATCH_OUT
);

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers

  // opcode class of an instruction word
  function automatic op_e dec_op(input logic [INSTR_W-1:0] w);
    if (w[OPC_MSB:PF_LSB] == PF_CODE)        return OP_PF_MOVE;
    else if (w[OPC_MSB:WF_LSB] == WF_CODE)   return OP_WF_MOVE;
    else if (w[OPC_MSB:SWAP_LSB] == SWAP_CODE) return OP_SWAP;
    else if (w[OPC_MSB:TBL_LSB] == TBL_CODE) return OP_TBL_RD;
    else                                     return OP_NONE;
  endfunction

  // effective file address, indirect slots replaced by their pointer
  function automatic logic [ADDR_W-1:0] eff_addr(input logic [ADDR_W-1:0] a,
                                                 input logic [ADDR_W-1:0] p0,
                                                 input logic [ADDR_W-1:0] p1);
    if (a == IND0_ADDR)      return p0;
    else if (a == IND1_ADDR) return p1;
    else                     return a;
  endfunction

  state_e            st;
  state_e            next_st;
  phase_e            q;
  phase_e            next_q;
  op_e               op;
  op_e               next_op;
  op_e               op_in;
  logic [ADDR_W-1:0] dst;
  logic [ADDR_W-1:0] next_dst;
  logic              sel;
  logic              next_sel;
  logic              inc;
  logic              next_inc;
  logic              program_counter_low;
  logic              next_pcl;
  logic [DATA_W-1:0] data;
  logic [DATA_W-1:0] next_data;
  logic [ADDR_W-1:0] f_eff;
  logic [ADDR_W-1:0] p_eff;
  logic              accept;
  logic              next_busy;
  logic [ADDR_W-1:0] next_rd_addr;
  logic [ADDR_W-1:0] next_wr_addr;
  logic [DATA_W-1:0] next_wr_data;
  logic              next_wr_en;
  logic              next_zwe;
  logic              next_z;
  logic [PROG_W-1:0] next_paddr;
  logic              next_oe_n;
  logic [PROG_W-1:0] next_ptr;
  logic [PROG_W-1:0] next_latch;

  swap_if sw ();

  nibble_swap_unit u_swap (
    .sw (sw.unit)
  );

  assign sw.raw = RD_DATA_IN;

  ////////////////////////////////////////////////////////////////////////////
  // operand addressing

  // source field is zero-extended, so only the lowest 32 are reachable
  // both operands pass through the indirect substitution
  assign p_eff  = eff_addr({{SRC_PAD{1'b0}}, INSTR_IN[SRC_MSB:SRC_LSB]}, FSR0_IN, FSR1_IN);
  assign f_eff  = eff_addr(INSTR_IN[FILE_MSB:FILE_LSB], FSR0_IN, FSR1_IN);
  assign op_in  = dec_op(INSTR_IN);
  // unknown opcodes are simply not taken; another unit owns them
  assign accept = (st == S_IDLE) && INSTR_VALID_IN && (op_in != OP_NONE);

  ////////////////////////////////////////////////////////////////////////////
  // sequencer next state; outputs change one phase after the decision

  always_comb begin
    next_st      = st;
    next_q       = phase_e'(q + 2'h1);
    next_op      = op;
    next_dst     = dst;
    next_sel     = sel;
    next_inc     = inc;
    next_pcl     = program_counter_low;
    next_data    = data;
    next_rd_addr = RD_ADDR_OUT;
    next_wr_addr = WR_ADDR_OUT;
    next_wr_data = WR_DATA_OUT;
    next_wr_en   = 1'b0;
    next_zwe     = 1'b0;
    next_z       = ZERO_OUT;
    next_paddr   = PROG_ADDR_OUT;
    next_oe_n    = 1'b1;
    next_ptr     = PTR_OUT;
    next_latch   = LATCH_OUT;
    case (st)
      S_IDLE: begin
        next_q = PH_Q1;
        // pointer loads only between instructions, so a fetch never sees it move
        if (PTR_LOAD_IN) begin
          next_ptr = PTR_DATA_IN;
        end
        if (accept) begin
          next_st  = S_C1;
          next_q   = PH_Q2;
          next_op  = op_in;
          next_sel = INSTR_IN[SEL_BIT];
          next_inc = INSTR_IN[INC_BIT];
          next_pcl = (f_eff == PCL_ADDR);
          next_dst = f_eff;
          // swap with d clear lands in the working register
          if (op_in == OP_SWAP && !INSTR_IN[DEST_BIT]) begin
            next_dst = WREG_ADDR;
          end
          // working register is an ordinary file location for either operand
          case (op_in)
            OP_PF_MOVE: next_rd_addr = p_eff;
            OP_WF_MOVE: next_rd_addr = WREG_ADDR;
            OP_SWAP:    next_rd_addr = f_eff;
            default:    next_rd_addr = RD_ADDR_OUT;
          endcase
        end
      end
      S_C1: begin
        case (q)
          PH_Q2: begin
            // table read picks a latch byte instead of a file read
            if (op == OP_TBL_RD) begin
              next_data = sel ? LATCH_OUT[PROG_W-1:DATA_W] : LATCH_OUT[DATA_W-1:0];
            end else if (op == OP_SWAP) begin
              next_data = sw.swapped;
            end else begin
              next_data = RD_DATA_IN;
            end
          end
          PH_Q3: begin
            // write the processed byte in Q4
            next_wr_en   = 1'b1;
            next_wr_addr = dst;
            next_wr_data = data;
            // only the peripheral move touches the zero flag
            if (op == OP_PF_MOVE) begin
              next_zwe = 1'b1;
              next_z   = (data == ZERO_BYTE);
            end
          end
          PH_Q4: begin
            next_st = (op == OP_TBL_RD) ? S_C2 : S_IDLE;
          end
          default: begin
            next_st = st;
          end
        endcase
      end
      S_C2: begin
        case (q)
          PH_Q1: begin
            // pointer on the program address bus from Q2
            next_paddr = PTR_OUT;
          end
          PH_Q3: begin
            next_oe_n = 1'b0;
          end
          PH_Q4: begin
            // capture the word at the close of Q4
            next_latch = PROG_DATA_IN;
            // conditional pointer step after the fetch
            next_ptr   = PTR_OUT + {{(PROG_W-1){1'b0}}, inc};
            // extra cycle when program counter low was written
            next_st    = program_counter_low ? S_C3 : S_IDLE;
          end
          default: begin
            next_st = st;
          end
        endcase
      end
      S_C3: begin
        if (q == PH_Q4) begin
          next_st = S_IDLE;
        end
      end
      default: begin
        next_st = S_IDLE;
      end
    endcase
    next_busy = (next_st != S_IDLE);
  end

  // registers only
  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      st            <= S_IDLE;
      q             <= PH_Q1;
      op            <= OP_NONE;
      dst           <= ADDR_RST;
      sel           <= 1'b0;
      inc           <= 1'b0;
      program_counter_low           <= 1'b0;
      data          <= DATA_RST;
      BUSY_OUT      <= 1'b0;
      RD_ADDR_OUT   <= ADDR_RST;
      WR_ADDR_OUT   <= ADDR_RST;
      WR_DATA_OUT   <= DATA_RST;
      WR_EN_OUT     <= 1'b0;
      ZERO_WE_OUT   <= 1'b0;
      ZERO_OUT      <= 1'b0;
      PROG_ADDR_OUT <= PTR_RST;
      PROG_OE_N_OUT <= 1'b1;
      PTR_OUT       <= PTR_RST;
      LATCH_OUT     <= LATCH_RST;
    end else begin
      st            <= next_st;
      q             <= next_q;
      op            <= next_op;
      dst           <= next_dst;
      sel           <= next_sel;
      inc           <= next_inc;
      program_counter_low           <= next_pcl;
      data          <= next_data;
      BUSY_OUT      <= next_busy;
      RD_ADDR_OUT   <= next_rd_addr;
      WR_ADDR_OUT   <= next_wr_addr;
      WR_DATA_OUT   <= next_wr_data;
      WR_EN_OUT     <= next_wr_en;
      ZERO_WE_OUT   <= next_zwe;
      ZERO_OUT      <= next_z;
      PROG_ADDR_OUT <= next_paddr;
      PROG_OE_N_OUT <= next_oe_n;
      PTR_OUT       <= next_ptr;
      LATCH_OUT     <= next_latch;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge MCLK_IN); endclocking
  default disable iff (RST_IN);

  a_move_copy_data: assert property ((st == S_C1 && q == PH_Q2 && op == OP_PF_MOVE) |-> ##2
    (WR_EN_OUT && WR_DATA_OUT == $past(RD_DATA_IN, 2)))
    else $error("move did not copy source byte");
  a_src_low_range: assert property ((accept && op_in == OP_PF_MOVE &&
    INSTR_IN[SRC_MSB:SRC_LSB] != IND0_ADDR[SRC_MSB-SRC_LSB:0] &&
    INSTR_IN[SRC_MSB:SRC_LSB] != IND1_ADDR[SRC_MSB-SRC_LSB:0]) |=> (RD_ADDR_OUT < 8'h20))
    else $error("source address beyond lowest 32");
  a_indirect_src: assert property ((accept && op_in == OP_PF_MOVE &&
    {{SRC_PAD{1'b0}}, INSTR_IN[SRC_MSB:SRC_LSB]} == IND0_ADDR) |=> (RD_ADDR_OUT == $past(FSR0_IN)))
    else $error("indirect source not taken from pointer");
  a_swap_nibbles: assert property ((st == S_C1 && q == PH_Q2 && op == OP_SWAP) |-> ##2
    (WR_DATA_OUT == {$past(RD_DATA_IN[3:0], 2), $past(RD_DATA_IN[7:4], 2)}))
    else $error("swap result wrong");
  a_swap_to_wreg: assert property ((accept && op_in == OP_SWAP && !INSTR_IN[DEST_BIT]) |-> ##3
    (WR_EN_OUT && WR_ADDR_OUT == WREG_ADDR))
    else $error("swap with d clear missed working register");
  a_latch_byte_sel: assert property ((st == S_C1 && q == PH_Q3 && op == OP_TBL_RD) |=>
    (WR_DATA_OUT == (sel ? LATCH_OUT[15:8] : LATCH_OUT[7:0])))
    else $error("wrong latch byte moved");
  a_latch_load: assert property ((st == S_C2 && q == PH_Q4) |=>
    (LATCH_OUT == $past(PROG_DATA_IN)))
    else $error("latch not loaded from program word");
  a_ptr_step: assert property ((st == S_C2 && q == PH_Q4) |=>
    (PTR_OUT == $past(PTR_OUT) + {15'h0000, $past(inc)}))
    else $error("pointer step wrong");
  a_tbl_two_cycles: assert property ((accept && op_in == OP_TBL_RD && f_eff != PCL_ADDR) |=>
    BUSY_OUT [*7] ##1 !BUSY_OUT)
    else $error("table read not two cycles");
  a_tbl_three_cycles: assert property ((accept && op_in == OP_TBL_RD && f_eff == PCL_ADDR) |=>
    BUSY_OUT [*8] ##1 BUSY_OUT [*3] ##1 !BUSY_OUT)
    else $error("table read to pcl not three cycles");
  a_fetch_strobe: assert property ((st == S_C2 && q == PH_Q3) |=>
    (!PROG_OE_N_OUT && PROG_ADDR_OUT == PTR_OUT) ##1 PROG_OE_N_OUT)
    else $error("fetch strobe or address wrong");
  a_wreg_move: assert property ((accept && op_in == OP_WF_MOVE) |-> ##3
    (WR_EN_OUT && !ZERO_WE_OUT && WR_ADDR_OUT == $past(f_eff, 3)))
    else $error("working register move wrong");

  c_pf_move: cover property (accept && op_in == OP_PF_MOVE);
  c_swap_back: cover property (accept && op_in == OP_SWAP && INSTR_IN[DEST_BIT]);
  c_tbl_inc: cover property (st == S_C2 && q == PH_Q4 && inc);
  c_tbl_pcl: cover property (st == S_C3 && q == PH_Q4);

endmodule

// *** dv/prog_file_model.sv ***
/*
  Behavioural data file and program memory facing the execution block.
  Assumes one clock: file reads answer in the same phase, writes land on
  the edge that sees the write enable, program words only while enabled.
*/
`timescale 1ns/1ns
module prog_file_model
  import exec_pkg::*;
(
  input  wire logic              clk_in,
  input  wire logic [ADDR_W-1:0] rd_addr_in,
  input  wire logic [ADDR_W-1:0] wr_addr_in,
  input  wire logic [DATA_W-1:0] wr_data_in,
  input  wire logic              wr_en_in,
  input  wire logic [PROG_W-1:0] prog_addr_in,
  input  wire logic              prog_oe_n_in,
  output logic      [DATA_W-1:0] rd_data_out,
  output logic      [PROG_W-1:0] prog_data_out
);
  logic [DATA_W-1:0] mem [256];
  logic [PROG_W-1:0] last;

  ////////////////////////////////////////////////////////////////////////////
  // known contents so that a stray read never looks like a match
  initial begin
    last = 16'h0000;
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'hEE;
    end
  end

  // file read answers combinationally
  assign rd_data_out   = mem[rd_addr_in];
  // released bus shows the inverse of the last word, never a stale copy
  assign prog_data_out = prog_oe_n_in ? ~last : (prog_addr_in ^ 16'h5AC3);

  // writes and last driven word
  always @(posedge clk_in) begin
    if (wr_en_in === 1'b1) mem[wr_addr_in] <= wr_data_in;
    if (prog_oe_n_in === 1'b0) last <= prog_addr_in ^ 16'h5AC3;
  end
endmodule

// *** dv/testbench.sv ***
/*
  Self-checking bench for the move / swap / table-read executor.
  Assumes the partner model supplies file and program memory; program
  words are the address scrambled with 16'h5AC3.
*/
`timescale 1ns/1ns
`define CHK(g, e) check_val(16'(g), 16'(e))
module testbench
  import exec_pkg::*;
;
  logic        mclk = 1'b0, rst = 1'b1, instr_valid = 1'b0, ptr_load = 1'b0;
  logic [15:0] instr = 16'h0000, ptr_data = 16'h0000, prog_data, prog_addr, ptr, latch;
  logic [7:0]  fsr0 = 8'h00, fsr1 = 8'h00, rd_data, rd_addr, wr_addr, wr_data;
  logic        busy, wr_en, zero_we, zero, oe_n;
  int          n_mismatch = 0, comparisons = 0, oe_cnt = 0, zwe_cnt = 0;
  logic [15:0] oe_addr;

  always #20 mclk = ~mclk;

  move_swap_table_read_exec uut (
    .MCLK_IN(mclk), .RST_IN(rst), .INSTR_VALID_IN(instr_valid), .INSTR_IN(instr),
    .FSR0_IN(fsr0), .FSR1_IN(fsr1), .RD_DATA_IN(rd_data), .PROG_DATA_IN(prog_data),
    .PTR_LOAD_IN(ptr_load), .PTR_DATA_IN(ptr_data), .BUSY_OUT(busy),
    .RD_ADDR_OUT(rd_addr), .WR_ADDR_OUT(wr_addr), .WR_DATA_OUT(wr_data),
    .WR_EN_OUT(wr_en), .ZERO_WE_OUT(zero_we), .ZERO_OUT(zero),
    .PROG_ADDR_OUT(prog_addr), .PROG_OE_N_OUT(oe_n), .PTR_OUT(ptr), .LATCH_OUT(latch)
  );

  prog_file_model m (
    .clk_in(mclk), .rd_addr_in(rd_addr), .wr_addr_in(wr_addr), .wr_data_in(wr_data),
    .wr_en_in(wr_en), .prog_addr_in(prog_addr), .prog_oe_n_in(oe_n),
    .rd_data_out(rd_data), .prog_data_out(prog_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // count fetch strobes and zero flag writes, keep the fetch address
  always @(posedge mclk) begin
    if (oe_n === 1'b0) begin
      oe_cnt++;
      oe_addr = prog_addr;
    end
    if (zero_we === 1'b1) begin
      zwe_cnt++;
    end
  end

  task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    $display("comparisons=%0d mismatches=%0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // offer one instruction, then time how long busy stands
  task automatic issue(input logic [15:0] word, input int busy_exp);
    int n;
    n = 0;
    @(posedge mclk);
    instr_valid <= 1'b1;
    instr       <= word;
    @(posedge mclk);
    instr_valid <= 1'b0;
    #1;
    while (busy === 1'b1 && n < 20) begin
      @(posedge mclk);
      #1;
      n++;
    end
    if (n == 20) begin
      n_mismatch++;
      summarize();
    end
    `CHK(n, busy_exp);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    `CHK({busy, wr_en, zero_we, zero, oe_n}, 5'h01);
    `CHK(ptr, PTR_RST);
    `CHK(latch, LATCH_RST);
    $display("test reset done");
  endtask

  task automatic t_pmove();
    m.mem[8'h05] = 8'h11;
    m.mem[8'h1F] = 8'h00;
    m.mem[8'h0A] = 8'h5C;
    m.mem[8'h03] = 8'h66;
    m.mem[8'h13] = 8'h9A;
    zwe_cnt = 0;
    issue({3'h2, 5'h05, 8'h40}, 3);
    `CHK(m.mem[8'h40], 8'h11);
    `CHK(zero, 1'b0);
    issue({3'h2, 5'h1F, 8'hFF}, 3);
    `CHK(m.mem[8'hFF], 8'h00);
    `CHK(zero, 1'b1);
    issue({3'h2, 5'h0A, 8'h70}, 3);
    `CHK(m.mem[8'h70], 8'h5C);
    issue({3'h2, 5'h03, 8'h0A}, 3);
    `CHK(m.mem[8'h0A], 8'h66);
    @(posedge mclk);
    fsr0 <= 8'h13;
    fsr1 <= 8'hC0;
    issue({3'h2, 5'h00, 8'h08}, 3);
    `CHK(m.mem[8'hC0], 8'h9A);
    `CHK(zero, 1'b0);
    `CHK(zwe_cnt, 5);
    $display("test peripheral move done");
  endtask

  task automatic t_wmove();
    m.mem[8'h0A] = 8'h00;
    m.mem[8'hC3] = 8'h77;
    issue(16'h01C3, 3);
    `CHK(m.mem[8'hC3], 8'h00);
    `CHK(zero, 1'b0);
    `CHK(zwe_cnt, 5);
    $display("test work register move done");
  endtask

  task automatic t_swap();
    m.mem[8'h20] = 8'h53;
    issue(16'h1C20, 3);
    `CHK(m.mem[8'h0A], 8'h35);
    `CHK(m.mem[8'h20], 8'h53);
    issue(16'h1D20, 3);
    `CHK(m.mem[8'h20], 8'h35);
    $display("test swap done");
  endtask

  task automatic t_table();
    @(posedge mclk);
    ptr_load <= 1'b1;
    ptr_data <= 16'h1234;
    @(posedge mclk);
    ptr_load <= 1'b0;
    m.mem[8'h30] = 8'hAA;
    oe_cnt = 0;
    issue({6'h2A, 1'b1, 1'b1, 8'h30}, 7);
    `CHK(m.mem[8'h30], 8'h00);
    `CHK(latch, 16'h1234 ^ 16'h5AC3);
    `CHK(ptr, 16'h1235);
    `CHK(oe_cnt, 1);
    `CHK(oe_addr, 16'h1234);
    issue({6'h2A, 1'b1, 1'b0, 8'h31}, 7);
    `CHK(m.mem[8'h31], 8'h48);
    `CHK(ptr, 16'h1235);
    `CHK(latch, 16'h1235 ^ 16'h5AC3);
    issue({6'h2A, 1'b0, 1'b1, PCL_ADDR_DEF}, 11);
    `CHK(m.mem[PCL_ADDR_DEF], 8'hF6);
    `CHK(ptr, 16'h1236);
    `CHK(oe_cnt, 3);
    $display("test table read done");
  endtask

  // an unknown opcode must leave the block idle
  task automatic t_refuse();
    issue(16'hFFFF, 0);
    `CHK(wr_en, 1'b0);
    $display("test refused opcode done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    #1;
    t_reset();
    t_pmove();
    t_wmove();
    t_swap();
    t_table();
    t_refuse();
    summarize();
  end
endmodule
